// >>> design/mafi_core.sv
/*
  Automatic fault check and interrupt control of one microcore, with its
  registers on an AHB-Lite slave port. Assumes the sequencer presents one
  decoded instruction per INSTR_VALID cycle and obeys PC_CMD loads, and
  that fault comparator inputs are synchronous to CLK.
*/
// Design decision made here: the AHB-Lite slave port.
// Behaviour
// - the single fault check opcode switches diagnosis of one feedback, bit 0 on or off.
// - selector codes 0-9 pick high-side 1-5 drain/source feedbacks, 10-15 low-side 1-6 drain.
// - any enable operation acts only on outputs this core has drive right for.
// - all monitors, shortcut monitors included, are off after reset.
// - the global fault check opcode applies bit 0 to every output the core may drive.
// - a satisfied enabled diagnosis starts the error interrupt routine.
// - the shortcut opcode controls four monitors resolved through the shortcut map.
// - each 2-bit shortcut field keeps on 00, is void on 01, disables on 10, enables on 11.
// - shortcut fields sit in bits 7:6, 5:4, 3:2 and 1:0 under opcode bits 15..8.
// - the return policy ignores (00), resumes (10) or restarts (11) on a return request.
// - a setup bit picks driver re-enable or a state register access as return request.
// - the return policy resets to ignore.
// - the return opcode ends the routine and clears the saved address in the interrupt state register.
// - return style 0 resumes at the saved address, 1 at the entry point register.
// - the flush bit of the return opcode clears the pending interrupt queue.
`include "mafi_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mafi_core (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output var logic [31:0] HRDATA,
  output var logic HREADYOUT,
  output var logic HRESP,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic [9:0] CORE_PC,
  input wire logic [15:0] FB_FAULT,
  input wire logic [3:0] SC_FAULT,
  input wire mafi_pkg::mafi_sc_map_t SC_MAP,
  input wire logic DRV_REENABLE,
  output var mafi_pkg::mafi_pc_cmd_t PC_CMD,
  output var logic INT_ACTIVE,
  output var logic IRQ
);

  logic [15:0] entry_q [4];
  logic [15:0] right_q [4];
  logic [15:0] setup_q, diag_en_q, latch_q;
  logic [3:0] sc_en_q, sc_latch_q;
  logic [1:0] policy_q;
  logic [9:0] saved_pc_q;
  logic pending_q, wr_pend_q;
  logic [2:0] irq_en_q, irq_stat, irq_set, irq_clr;
  mafi_pkg::mafi_state_t state_q;
  logic [11:0] wr_idx_q;

  logic [11:0] out_right, a_idx;
  logic [15:0] fb_right, fb_hit, lat_clr;
  logic [3:0] sc_right, sc_hit;
  logic trig, ret_req, addr_ok, rd_stb, pds_access;
  logic [31:0] rd_d;
  logic op_single, op_global, op_short, op_iconf, op_iret;

  // instruction decode
  assign op_single = INSTR_VALID && (INSTR[15:5] == `MAFI_OP_SINGLE);
  assign op_global = INSTR_VALID && (INSTR[15:1] == `MAFI_OP_GLOBAL);
  assign op_short = INSTR_VALID && (INSTR[15:8] == `MAFI_OP_SHORT);
  assign op_iconf = INSTR_VALID && (INSTR[15:2] == `MAFI_OP_ICONF);
  assign op_iret = INSTR_VALID && (INSTR[15:2] == `MAFI_OP_IRET);

  // drive right per output, then per feedback and per shortcut
  always_comb begin
    out_right = '0;
    for (int r = 0; r < 4; r++) begin
      out_right = out_right | right_q[r][11:0];
    end
    for (int i = 0; i < 16; i++) begin
      fb_right[i] = (i < 10) ? out_right[i / 2] : out_right[i - 5];
    end
    sc_right[0] = (SC_MAP.sc1 < `MAFI_SC_UNDEF) && out_right[SC_MAP.sc1];
    sc_right[1] = sc_right[0];
    sc_right[2] = (SC_MAP.sc2 < `MAFI_SC_UNDEF) && out_right[SC_MAP.sc2];
    sc_right[3] = (SC_MAP.sc3 < `MAFI_SC_UNDEF) && out_right[SC_MAP.sc3];
  end

  // a fault counts only where monitored and driven
  assign fb_hit = FB_FAULT & diag_en_q & fb_right;
  assign sc_hit = SC_FAULT & sc_en_q & sc_right;
  assign trig = (|(fb_hit & ~latch_q)) || (|(sc_hit & ~sc_latch_q));

  // bus address phase
  assign a_idx = HADDR[13:2];
  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign rd_stb = addr_ok && !HWRITE;
  assign pds_access = addr_ok && (HADDR[31:14] == '0) && (a_idx == `MAFI_IDX_PDSTATE);
  assign ret_req = setup_q[`MAFI_SETUP_RETSRC_BIT] ? pds_access : DRV_REENABLE;

  // state register clears on read when so configured, or on written ones
  always_comb begin
    lat_clr = '0;
    if (pds_access && rd_stb && setup_q[`MAFI_SETUP_RDCLR_BIT]) begin
      lat_clr = '1;
    end else if (wr_pend_q && (wr_idx_q == `MAFI_IDX_PDSTATE)) begin
      lat_clr = HWDATA[15:0];
    end
  end

  // fault latches: a new hit wins over a clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      latch_q <= '0;
      sc_latch_q <= '0;
    end else begin
      latch_q <= fb_hit | (latch_q & ~lat_clr);
      sc_latch_q <= sc_hit | (sc_latch_q & ~lat_clr[3:0]);
    end
  end

  // monitor enables, changed only where drive right is held
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      diag_en_q <= '0;
      sc_en_q <= '0;
    end else if (op_single) begin
      if (fb_right[INSTR[4:1]]) begin
        diag_en_q[INSTR[4:1]] <= INSTR[0];
      end
    end else if (op_global) begin
      for (int i = 0; i < 16; i++) begin
        if (fb_right[i]) begin
          diag_en_q[i] <= INSTR[0];
        end
      end
      for (int j = 0; j < 4; j++) begin
        if (sc_right[j]) begin
          sc_en_q[j] <= INSTR[0];
        end
      end
    end else if (op_short) begin
      // monitor j takes field bits 7-2j:6-2j; 00 and 01 leave it alone
      for (int j = 0; j < 4; j++) begin
        if (INSTR[7 - 2 * j] && sc_right[j]) begin
          sc_en_q[j] <= INSTR[6 - 2 * j];
        end
      end
    end
  end

  // return policy, the void code is not taken
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      policy_q <= `MAFI_POL_IGNORE;
    end else if (op_iconf && (INSTR[1:0] != `MAFI_POL_NA)) begin
      policy_q <= INSTR[1:0];
    end
  end

  // interrupt sequencing; iret takes priority over a return request
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= mafi_pkg::ST_RUN;
      saved_pc_q <= '0;
      pending_q <= 1'b0;
      PC_CMD <= '0;
    end else begin
      PC_CMD.load <= 1'b0;
      case (state_q)
        mafi_pkg::ST_RUN: begin
          if (trig || pending_q) begin
            state_q <= mafi_pkg::ST_ISR;
            saved_pc_q <= CORE_PC;
            pending_q <= 1'b0;
            PC_CMD <= '{load: 1'b1, addr: `MAFI_ISR_VECTOR};
          end
        end
        mafi_pkg::ST_ISR: begin
          if (op_iret) begin
            state_q <= mafi_pkg::ST_RUN;
            saved_pc_q <= '0;
            pending_q <= INSTR[0] ? 1'b0 : (pending_q || trig);
            PC_CMD.load <= 1'b1;
            PC_CMD.addr <= INSTR[1] ? entry_q[0][9:0] : saved_pc_q;
          end else if (ret_req && policy_q[1]) begin
            state_q <= mafi_pkg::ST_RUN;
            saved_pc_q <= '0;
            pending_q <= pending_q || trig;
            PC_CMD.load <= 1'b1;
            PC_CMD.addr <= policy_q[0] ? entry_q[0][9:0] : saved_pc_q;
          end else if (trig) begin
            pending_q <= 1'b1;
          end
        end
        default: begin
          state_q <= mafi_pkg::ST_RUN;
        end
      endcase
    end
  end

  assign irq_set = {op_iret && (state_q == mafi_pkg::ST_ISR),
                    ret_req && policy_q[1] && (state_q == mafi_pkg::ST_ISR), trig};
  assign irq_clr = (wr_pend_q && (wr_idx_q == `MAFI_IDX_IRQ_CLR)) ? HWDATA[2:0] : 3'h0;

  // sticky event flags: fault, return request, routine end
  mafi_sticky #(
    .W(`MAFI_NUM_IRQ)
  ) u_irq_stat (
    .clk(CLK),
    .rst(RESET),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_stat)
  );

  // level interrupt, registered so the pin comes from a flop
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      IRQ <= 1'b0;
      INT_ACTIVE <= 1'b0;
    end else begin
      IRQ <= |(irq_stat & irq_en_q);
      INT_ACTIVE <= (state_q == mafi_pkg::ST_ISR);
    end
  end

  // read mux, unmapped and write-only locations read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (HADDR[31:14] != '0) begin
      rd_d = 32'h0000_0000;
    end else if (a_idx == `MAFI_IDX_ENTRY0A) begin
      rd_d[15:0] = entry_q[0];
    end else if (a_idx == `MAFI_IDX_ENTRY0B) begin
      rd_d[15:0] = entry_q[1];
    end else if (a_idx == `MAFI_IDX_ENTRY1A) begin
      rd_d[15:0] = entry_q[2];
    end else if (a_idx == `MAFI_IDX_ENTRY1B) begin
      rd_d[15:0] = entry_q[3];
    end else if (a_idx[11:2] == 10'(`MAFI_IDX_RIGHT0 >> 2)) begin
      rd_d[15:0] = right_q[a_idx[1:0]];
    end else if (a_idx == `MAFI_IDX_SETUP) begin
      rd_d[15:0] = setup_q;
    end else if (a_idx == `MAFI_IDX_PDSTATE) begin
      rd_d[15:0] = latch_q;
    end else if (a_idx == `MAFI_IDX_INTSTATE) begin
      rd_d[15:0] = {state_q == mafi_pkg::ST_ISR, pending_q, 4'h0, saved_pc_q};
    end else if (a_idx == `MAFI_IDX_IRQ_STAT) begin
      rd_d[2:0] = irq_stat;
    end else if (a_idx == `MAFI_IDX_IRQ_EN) begin
      rd_d[2:0] = irq_en_q;
    end else if (a_idx == `MAFI_IDX_MONITOR) begin
      rd_d = {6'h00, policy_q, sc_latch_q, sc_en_q, diag_en_q};
    end
  end

  // bus slave: zero wait states, always OKAY
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 12'h000;
    end else begin
      HRDATA <= rd_stb ? rd_d : 32'h0000_0000;
      wr_pend_q <= addr_ok && HWRITE && (HADDR[31:14] == '0);
      wr_idx_q <= a_idx;
    end
  end

  // software-written registers, written in the data phase
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (int k = 0; k < 4; k++) begin
        entry_q[k] <= 16'h0000;
        right_q[k] <= 16'h0000;
      end
      setup_q <= 16'h0000;
      irq_en_q <= 3'h0;
    end else if (wr_pend_q) begin
      if (wr_idx_q == `MAFI_IDX_ENTRY0A) begin
        entry_q[0] <= HWDATA[15:0];
      end else if (wr_idx_q == `MAFI_IDX_ENTRY0B) begin
        entry_q[1] <= HWDATA[15:0];
      end else if (wr_idx_q == `MAFI_IDX_ENTRY1A) begin
        entry_q[2] <= HWDATA[15:0];
      end else if (wr_idx_q == `MAFI_IDX_ENTRY1B) begin
        entry_q[3] <= HWDATA[15:0];
      end else if (wr_idx_q[11:2] == 10'(`MAFI_IDX_RIGHT0 >> 2)) begin
        right_q[wr_idx_q[1:0]] <= HWDATA[15:0];
      end else if (wr_idx_q == `MAFI_IDX_SETUP) begin
        setup_q <= HWDATA[15:0];
      end else if (wr_idx_q == `MAFI_IDX_IRQ_EN) begin
        irq_en_q <= HWDATA[2:0];
      end
    end
  end

  // checks
  property p_single_on;
    @(posedge CLK) disable iff (RESET)
    (op_single && fb_right[INSTR[4:1]] && INSTR[0]) |=> diag_en_q[$past(INSTR[4:1])];
  endproperty
  a_single_on: assert property (p_single_on) else $error("single enable not applied");
  property p_no_right;
    @(posedge CLK) disable iff (RESET)
    (op_single && !fb_right[INSTR[4:1]]) |=> $stable(diag_en_q);
  endproperty
  a_no_right: assert property (p_no_right) else $error("monitor changed without right");
  property p_global_off;
    @(posedge CLK) disable iff (RESET)
    (op_global && !INSTR[0]) |=> ((diag_en_q & $past(fb_right)) == 16'h0000);
  endproperty
  a_global_off: assert property (p_global_off) else $error("global disable missed");
  property p_sc_keep;
    @(posedge CLK) disable iff (RESET)
    (op_short && !INSTR[7]) |=> (sc_en_q[0] == $past(sc_en_q[0]));
  endproperty
  a_sc_keep: assert property (p_sc_keep) else $error("shortcut keep altered monitor");
  property p_enter;
    @(posedge CLK) disable iff (RESET)
    (state_q == mafi_pkg::ST_RUN && trig) |=> (state_q == mafi_pkg::ST_ISR)
      && PC_CMD.load && (PC_CMD.addr == `MAFI_ISR_VECTOR) ##1 INT_ACTIVE;
  endproperty
  a_enter: assert property (p_enter) else $error("fault did not enter routine");
  property p_resume;
    @(posedge CLK) disable iff (RESET)
    (state_q == mafi_pkg::ST_ISR && op_iret && !INSTR[1]) |=> PC_CMD.load
      && (PC_CMD.addr == $past(saved_pc_q)) && (saved_pc_q == 10'h000);
  endproperty
  a_resume: assert property (p_resume) else $error("iret resume address wrong");
  property p_flush;
    @(posedge CLK) disable iff (RESET)
    (state_q == mafi_pkg::ST_ISR && op_iret && INSTR[0]) |=> !pending_q;
  endproperty
  a_flush: assert property (p_flush) else $error("queue not flushed");
  property p_ignore;
    @(posedge CLK) disable iff (RESET)
    (state_q == mafi_pkg::ST_ISR && policy_q == `MAFI_POL_IGNORE && !op_iret)
      |=> (state_q == mafi_pkg::ST_ISR) && !PC_CMD.load;
  endproperty
  a_ignore: assert property (p_ignore) else $error("return request not ignored");

  c_enter: cover property (@(posedge CLK) disable iff (RESET)
    state_q == mafi_pkg::ST_RUN && trig);
  c_iret_flush: cover property (@(posedge CLK) disable iff (RESET)
    state_q == mafi_pkg::ST_ISR && op_iret && INSTR[0] && pending_q);
  c_restart: cover property (@(posedge CLK) disable iff (RESET)
    state_q == mafi_pkg::ST_ISR && ret_req && policy_q == 2'b11 && !op_iret);

endmodule : mafi_core

`default_nettype wire

// >>> design/mafi_pkg.sv
/*
  Types of the fault and interrupt unit. Assumes nothing beyond the
  constants header.
*/
package mafi_pkg;

  // program counter load request toward the sequencer
  typedef struct packed {
    logic load;
    logic [9:0] addr;
  } mafi_pc_cmd_t;

  // shortcut map, one output code per shortcut
  typedef struct packed {
    logic [3:0] sc1;
    logic [3:0] sc2;
    logic [3:0] sc3;
  } mafi_sc_map_t;

  typedef enum logic {
    ST_RUN,
    ST_ISR
  } mafi_state_t;

endpackage : mafi_pkg

// >>> design/mafi_regs.svh
/*
  Register indices, field positions and opcode patterns of the fault and
  interrupt unit. Assumes byte address = 4 * index on the register bus.
*/
`ifndef MAFI_REGS_SVH
`define MAFI_REGS_SVH

// register indices (byte address is four times these)
`define MAFI_IDX_ENTRY0A 12'h10a
`define MAFI_IDX_ENTRY0B 12'h10b
`define MAFI_IDX_ENTRY1A 12'h12a
`define MAFI_IDX_ENTRY1B 12'h12b
`define MAFI_IDX_RIGHT0 12'h184
`define MAFI_IDX_RIGHT1 12'h185
`define MAFI_IDX_RIGHT2 12'h186
`define MAFI_IDX_RIGHT3 12'h187
`define MAFI_IDX_SETUP 12'h1c5
`define MAFI_IDX_PDSTATE 12'h1d2
`define MAFI_IDX_INTSTATE 12'h1d4
`define MAFI_IDX_IRQ_STAT 12'h1e0
`define MAFI_IDX_IRQ_CLR 12'h1e1
`define MAFI_IDX_IRQ_EN 12'h1e2
`define MAFI_IDX_MONITOR 12'h1e3

// setup register fields
`define MAFI_SETUP_RETSRC_BIT 0
`define MAFI_SETUP_RDCLR_BIT 1

// opcode patterns
`define MAFI_OP_SINGLE 11'b00110100110
`define MAFI_OP_GLOBAL 15'b001101100000000
`define MAFI_OP_SHORT 8'b00100110
`define MAFI_OP_ICONF 14'b00110110000001
`define MAFI_OP_IRET 14'b00110101100110

// return policy codes
`define MAFI_POL_IGNORE 2'b00
`define MAFI_POL_NA 2'b01

// misc values
`define MAFI_ISR_VECTOR 10'h3f0
`define MAFI_SC_UNDEF 4'hc
`define MAFI_NUM_FB 16
`define MAFI_NUM_OUT 12
`define MAFI_NUM_SC 4
`define MAFI_NUM_IRQ 3

`endif

// >>> design/mafi_sticky.sv
/*
  Sticky flag vector: set wins over clear in the same cycle.
  Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module mafi_sticky #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output var logic [W-1:0] q
);

  // a fresh event is never lost to a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= set | (q & ~clr);
    end
  end

endmodule : mafi_sticky

`default_nettype wire

// >>> test/mafi_seq_model.sv
/*
  Model of the program sequencer and fault comparators beside the fault unit.
  Assumes the bench requests one instruction word and fault levels per edge.
*/
`timescale 1ns/1ps
`default_nettype none

module mafi_seq_model (
  input wire logic clk,
  input wire logic rst,
  input wire mafi_pkg::mafi_pc_cmd_t pc_cmd,
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  input wire logic [15:0] fb_in,
  input wire logic [3:0] sc_in,
  output var logic instr_valid,
  output var logic [15:0] instr,
  output var logic [9:0] core_pc,
  output var logic [15:0] fb_fault,
  output var logic [3:0] sc_fault
);
  // program counter obeys loads, else steps one word a cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_pc <= 10'h000;
    end else begin
      core_pc <= pc_cmd.load ? pc_cmd.addr : core_pc + 10'h001;
    end
  end

  // fetch stage: idle cycles show a changing word, so a stale opcode never passes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_valid <= 1'b0;
      instr <= 16'h0000;
    end else begin
      instr_valid <= op_valid;
      instr <= op_valid ? op_word : ~instr;
    end
  end

  // comparator levels, one register stage like the analog front end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fb_fault <= 16'h0000;
      sc_fault <= 4'h0;
    end else begin
      fb_fault <= fb_in;
      sc_fault <= sc_in;
    end
  end
endmodule : mafi_seq_model
`default_nettype wire

// >>> test/testbench.sv
/*
  Self-checking bench of the fault and interrupt unit. Assumes the sequencer
  model beside it and byte address = 4 * register index.
*/
`include "mafi_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic INSTR_VALID;
  logic [15:0] INSTR;
  logic [9:0] CORE_PC;
  logic [15:0] FB_FAULT;
  logic [3:0] SC_FAULT;
  mafi_pkg::mafi_sc_map_t SC_MAP = '{sc1: 4'h0, sc2: 4'h5, sc3: 4'hc};
  logic DRV_REENABLE = 1'b0;
  mafi_pkg::mafi_pc_cmd_t PC_CMD;
  logic INT_ACTIVE;
  logic IRQ;
  logic op_valid = 1'b0;
  logic [15:0] op_word = 16'h0;
  logic [15:0] fb_in = 16'h0;
  logic [3:0] sc_in = 4'h0;
  logic [31:0] rdata;
  logic [9:0] saved;
  logic [9:0] load_log [$];
  int num_errors = 0;
  int compares = 0;
  int n;
  logic [11:0] reset_idx [9] = '{`MAFI_IDX_ENTRY0A, `MAFI_IDX_RIGHT0, `MAFI_IDX_RIGHT1,
    `MAFI_IDX_RIGHT3, `MAFI_IDX_SETUP, `MAFI_IDX_INTSTATE, `MAFI_IDX_IRQ_STAT,
    `MAFI_IDX_IRQ_EN, `MAFI_IDX_MONITOR};
  // opcode, then monitor word expected after it (rights: outputs 0..9, sc3 unmapped)
  logic [47:0] rows [14] = '{{16'h34c1, 32'h0000_0001}, {16'h34d3, 32'h0000_0201},
    {16'h34df, 32'h0000_0201}, {16'h34dd, 32'h0000_4201}, {16'h34c0, 32'h0000_4200},
    {16'h3601, 32'h0007_7fff}, {16'h2687, 32'h0006_7fff}, {16'h26f8, 32'h0003_7fff},
    {16'h3600, 32'h0000_0000}, {16'h3606, 32'h0200_0000}, {16'h3605, 32'h0200_0000},
    {16'h3607, 32'h0300_0000}, {16'h3604, 32'h0000_0000}, {16'h2630, 32'h0002_0000}};

  // 200 MHz clock
  always #2.5 CLK = ~CLK;

  mafi_core u_mafi_core (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .CORE_PC(CORE_PC), .FB_FAULT(FB_FAULT), .SC_FAULT(SC_FAULT),
    .SC_MAP(SC_MAP), .DRV_REENABLE(DRV_REENABLE), .PC_CMD(PC_CMD),
    .INT_ACTIVE(INT_ACTIVE), .IRQ(IRQ));

  mafi_seq_model u_mafi_seq_model (.clk(CLK), .rst(RESET), .pc_cmd(PC_CMD),
    .op_valid(op_valid), .op_word(op_word), .fb_in(fb_in), .sc_in(sc_in),
    .instr_valid(INSTR_VALID), .instr(INSTR), .core_pc(CORE_PC), .fb_fault(FB_FAULT),
    .sc_fault(SC_FAULT));

  // log every program counter load; a pulse lasts one cycle only
  always @(posedge CLK) begin
    if (PC_CMD.load === 1'b1) begin
      load_log.push_back(PC_CMD.addr);
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one single-word transfer; read data lands in rdata
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wdata);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {18'h0, idx, 2'h0};
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= wdata;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    rdata = HRDATA;
    check("hresp", {31'h0, HRESP}, 32'h0);
  endtask : bus

  // three edges: one through the fetch stage, one for the unit to take it, one spare
  task automatic op(input logic [15:0] w);
    op_valid <= 1'b1;
    op_word <= w;
    @(posedge CLK);
    op_valid <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : op

  task automatic pulse_reenable;
    DRV_REENABLE <= 1'b1;
    @(posedge CLK);
    DRV_REENABLE <= 1'b0;
    @(posedge CLK);
  endtask : pulse_reenable

  // looked at on the falling edge so the log is never read mid-update
  task automatic expect_load(input int n0, input logic [9:0] exp);
    int i;
    for (i = 0; i < 40 && load_log.size() <= n0; i++) @(negedge CLK);
    check("pc load address", {22'h0, load_log[n0]}, {22'h0, exp});
    @(posedge CLK);
  endtask : expect_load

  task automatic expect_quiet(input int n0);
    repeat (12) @(negedge CLK);
    check("pc load count", 32'(load_log.size()), 32'(n0));
    @(posedge CLK);
  endtask : expect_quiet

  task automatic test_done;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    test_done();
  end

  // main sequence: reset state, table rows, then interrupt paths
  initial begin
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    foreach (reset_idx[i]) begin
      bus(1'b0, reset_idx[i], 32'h0);
      check("reset value", rdata, 32'h0);
    end
    bus(1'b1, 12'h1ff, 32'hffff_ffff);
    bus(1'b0, 12'h1ff, 32'h0);
    check("unmapped read", rdata, 32'h0);
    bus(1'b1, `MAFI_IDX_RIGHT0, 32'h0000_001f);
    bus(1'b1, `MAFI_IDX_RIGHT2, 32'h0000_03e0);
    bus(1'b1, `MAFI_IDX_ENTRY0A, 32'h0000_0123);
    bus(1'b1, `MAFI_IDX_IRQ_EN, 32'h0000_0007);
    bus(1'b0, `MAFI_IDX_RIGHT2, 32'h0);
    check("drive right", rdata, 32'h0000_03e0);
    foreach (rows[i]) begin
      op(rows[i][47:32]);
      bus(1'b0, `MAFI_IDX_MONITOR, 32'h0);
      check("monitor", rdata & 32'h030f_ffff, rows[i][31:0]);
    end
    // fault entry, ignored return request, pending fault flushed by the return
    op(16'h34c5);
    op(16'h34c9);
    n = load_log.size();
    fb_in <= 16'h0004;
    expect_load(n, `MAFI_ISR_VECTOR);
    n = load_log.size();
    pulse_reenable();
    expect_quiet(n);
    fb_in <= 16'h0014;
    // one edge through the comparator stage, one for the unit to queue it
    repeat (2) @(posedge CLK);
    bus(1'b0, `MAFI_IDX_INTSTATE, 32'h0);
    check("pending and in routine", rdata & 32'h0000_c000, 32'h0000_c000);
    check("int active", {31'h0, INT_ACTIVE}, 32'h1);
    check("irq", {31'h0, IRQ}, 32'h1);
    saved = rdata[9:0];
    n = load_log.size();
    op(16'h3599);
    expect_load(n, saved);
    expect_quiet(n + 1);
    bus(1'b0, `MAFI_IDX_INTSTATE, 32'h0);
    check("int state cleared", rdata, 32'h0);
    check("int active", {31'h0, INT_ACTIVE}, 32'h0);
    // interrupt flags: seen, masked, cleared
    bus(1'b0, `MAFI_IDX_IRQ_STAT, 32'h0);
    check("irq status", rdata, 32'h0000_0005);
    bus(1'b1, `MAFI_IDX_IRQ_EN, 32'h0);
    bus(1'b0, `MAFI_IDX_IRQ_EN, 32'h0);
    check("irq enable", rdata, 32'h0);
    check("irq masked", {31'h0, IRQ}, 32'h0);
    bus(1'b1, `MAFI_IDX_IRQ_CLR, 32'h0000_0007);
    bus(1'b1, `MAFI_IDX_IRQ_EN, 32'h0000_0007);
    bus(1'b0, `MAFI_IDX_IRQ_STAT, 32'h0);
    check("irq status cleared", rdata, 32'h0);
    check("irq low", {31'h0, IRQ}, 32'h0);
    // restart return keeps the pending fault, then driver re-enable resumes
    op(16'h3606);
    fb_in <= 16'h0000;
    repeat (3) @(posedge CLK);
    // fault latches are sticky; a new entry needs them cleared first
    bus(1'b1, `MAFI_IDX_PDSTATE, 32'h0000_ffff);
    n = load_log.size();
    fb_in <= 16'h0004;
    expect_load(n, `MAFI_ISR_VECTOR);
    fb_in <= 16'h0014;
    repeat (2) @(posedge CLK);
    bus(1'b0, `MAFI_IDX_INTSTATE, 32'h0);
    check("pending", rdata & 32'h0000_4000, 32'h0000_4000);
    n = load_log.size();
    op(16'h359a);
    expect_load(n, 10'h123);
    expect_load(n + 1, `MAFI_ISR_VECTOR);
    bus(1'b0, `MAFI_IDX_INTSTATE, 32'h0);
    saved = rdata[9:0];
    n = load_log.size();
    pulse_reenable();
    expect_load(n, saved);
    // return request from a state register access, restart policy
    bus(1'b1, `MAFI_IDX_SETUP, 32'h0000_0003);
    op(16'h3607);
    fb_in <= 16'h0000;
    repeat (3) @(posedge CLK);
    bus(1'b1, `MAFI_IDX_PDSTATE, 32'h0000_ffff);
    n = load_log.size();
    fb_in <= 16'h0004;
    expect_load(n, `MAFI_ISR_VECTOR);
    n = load_log.size();
    bus(1'b0, `MAFI_IDX_PDSTATE, 32'h0);
    check("fault latch", rdata, 32'h0000_0004);
    expect_load(n, 10'h123);
    // second reset in mid-run
    RESET <= 1'b1;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    bus(1'b0, `MAFI_IDX_MONITOR, 32'h0);
    check("monitor after reset", rdata, 32'h0);
    check("int active after reset", {31'h0, INT_ACTIVE}, 32'h0);
    test_done();
  end
endmodule : testbench
`default_nettype wire
